// ==== logic/flp_defines.svh ====
// offsets, field values, reset values and table constants of the flash range protection block
// assumes the includer compiles flp_pkg alongside; definitions only
`ifndef FLP_DEFINES_SVH
`define FLP_DEFINES_SVH

`define FLP_ADDR_W      8
`define FLP_OFF_CFG     8'h00
`define FLP_OFF_STAT    8'h04
`define FLP_OFF_MASK    8'h08
`define FLP_OFF_CTRL    8'h0c

`define FLP_CFG_RST     8'h24
`define FLP_NUM_EV      2
`define FLP_EV_VIOL     0
`define FLP_EV_REFUSE   1
`define FLP_STAT_RST    2'h0
`define FLP_MASK_RST    2'h0

`define FLP_HI_BASE_00  16'hf800
`define FLP_HI_BASE_01  16'hf000
`define FLP_HI_BASE_10  16'he000
`define FLP_HI_BASE_11  16'hc000
`define FLP_LO_BASE     16'h4000
`define FLP_LO_END_00   16'h43ff
`define FLP_LO_END_01   16'h47ff
`define FLP_LO_END_10   16'h4fff
`define FLP_LO_END_11   16'h5fff

// row = current scenario, bit within row = requested scenario
`define FLP_PERM_TABLE  64'hff5a3c18080c0a0f
`define FLP_SCN_NONE    3'h7

`endif

// ==== logic/flp_pkg.sv ====
// types shared by the flash range protection block
// assumes nothing of its surroundings
package flp_pkg;

  typedef struct packed {
    logic       window_polarity;
    logic       spare_nv_bit;
    logic       high_window_off;
    logic [1:0] high_window_size;
    logic       low_window_off;
    logic [1:0] low_window_size;
  } flp_cfg_t;

  typedef enum logic [3:0] {
    FLP_CMD_PROG  = 4'h1,
    FLP_CMD_ERASE = 4'h2,
    FLP_CMD_MASS  = 4'h4,
    FLP_CMD_OTHER = 4'h8
  } flp_cmd_e;

  typedef struct packed {
    logic        valid;
    flp_cmd_e    kind;
    logic [15:0] addr;
  } flp_cmd_t;

endpackage

// ==== logic/flp_perm_rom.sv ====
// scenario move permission table, registered read
// assumes from/to are stable in the cycle before the answer is used
`timescale 1ns/1ns
`include "flp_defines.svh"

module flp_perm_rom (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] from_i,
  input  wire logic [2:0] to_i,
  output logic            allowed_o
);

  localparam logic [63:0] PERM = `FLP_PERM_TABLE;

  // fixed 8x8 table, one lookup every clock cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      allowed_o <= 1'b0;
    end else begin
      allowed_o <= PERM[{from_i, to_i}];
    end
  end

endmodule

// ==== logic/flp_protect.sv ====
// flash range protection: config register, move checks, address protection, violation flag
// assumes an apb master on clk_i and a flash command controller presenting cmd_i
//
// Function
// - high window off bit 5: 0 enables upper window, 1 disables it
// - low window off bit 2: 0 enables lower window, 1 disables it
// - high window size bits 4:3 writable only while high window off is set
// - low window size bits 1:0 writable only while low window off is set
// - high sizes 2/4/8/16 Kbytes ending at top, from f800 down to c000
// - low sizes 1/2/4/8 Kbytes from 4000, ending 43ff/47ff/4fff/5fff
// - polarity 1: enabled windows protected; both off means nothing protected
// - polarity 0: both off protects all; enabled windows are the only open space
// - setting comes from flash after reset, then software may change it
// - write to a disallowed scenario is dropped whole; protection only grows
// - reading the register returns the scenario currently in force
// - polarity bit only goes from 1 to 0; setting it is ignored
// - register loads from the stored protection byte during reset sequence
// - program/erase on protected address, or mass erase under protection, flags violation
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
`include "flp_defines.svh"

module flp_protect
  import flp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        nv_load_i,
  input  wire logic [7:0]  nv_byte_i,
  input  wire flp_cmd_t    cmd_i,
  output logic             addr_protected_o,
  output logic             protect_violation_flag_o,
  output logic             irq_o
);

  logic                   rst_q1;
  logic                   rst_n;
  flp_cfg_t               cfg;
  flp_cfg_t               wr_val;
  flp_cfg_t               cand;
  flp_cfg_t               cand_q;
  logic                   loaded;
  logic                   move_ok;
  logic [`FLP_NUM_EV-1:0] status;
  logic [`FLP_NUM_EV-1:0] mask;
  logic [`FLP_NUM_EV-1:0] ev;
  logic [`FLP_NUM_EV-1:0] clr;
  logic                   setup;
  logic                   access;
  logic                   wr_cfg;
  logic                   any_prot;
  logic                   c_pol;
  logic                   c_hoff;
  logic                   c_loff;
  logic [7:0]             cfg_bits;

  // async assert, synchronous release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  function automatic logic [15:0] hi_base(input logic [1:0] sz);
    case (sz)
      2'h0:    hi_base = `FLP_HI_BASE_00;
      2'h1:    hi_base = `FLP_HI_BASE_01;
      2'h2:    hi_base = `FLP_HI_BASE_10;
      default: hi_base = `FLP_HI_BASE_11;
    endcase
  endfunction

  function automatic logic [15:0] lo_end(input logic [1:0] sz);
    case (sz)
      2'h0:    lo_end = `FLP_LO_END_00;
      2'h1:    lo_end = `FLP_LO_END_01;
      2'h2:    lo_end = `FLP_LO_END_10;
      default: lo_end = `FLP_LO_END_11;
    endcase
  endfunction

  function automatic logic is_protected(input flp_cfg_t c, input logic [15:0] a);
    logic hit_hi;
    logic hit_lo;
    hit_hi = !c.high_window_off && (a >= hi_base(c.high_window_size));
    hit_lo = !c.low_window_off && (a >= `FLP_LO_BASE)
             && (a <= lo_end(c.low_window_size));
    // polarity swaps the meaning of the windows
    is_protected = c.window_polarity ? (hit_hi | hit_lo) : !(hit_hi | hit_lo);
  endfunction

  function automatic logic [2:0] scenario(input flp_cfg_t c);
    scenario = {c.window_polarity, c.high_window_off, c.low_window_off};
  endfunction

  assign c_pol    = cfg.window_polarity;
  assign c_hoff   = cfg.high_window_off;
  assign c_loff   = cfg.low_window_off;
  assign cfg_bits = cfg;
  assign any_prot = scenario(cfg) != `FLP_SCN_NONE;

  // candidate value of a register write
  always_comb begin
    wr_val                = flp_cfg_t'(pwdata_i[7:0]);
    cand                  = cfg;
    cand.window_polarity  = cfg.window_polarity & wr_val.window_polarity;
    cand.high_window_off  = wr_val.high_window_off;
    cand.low_window_off   = wr_val.low_window_off;
    if (cfg.high_window_off) begin
      cand.high_window_size = wr_val.high_window_size;
    end
    if (cfg.low_window_off) begin
      cand.low_window_size = wr_val.low_window_size;
    end
  end

  // table answer is ready in the access cycle, one cycle after setup
  flp_perm_rom u_perm (
    .clk_i     (clk_i),
    .nrst_i    (rst_n),
    .from_i    (scenario(cfg)),
    .to_i      (scenario(cand)),
    .allowed_o (move_ok)
  );

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;
  assign wr_cfg = access & pwrite_i & (paddr_i == `FLP_OFF_CFG);

  // apb answer: always one access cycle, no wait states
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      cand_q    <= flp_cfg_t'(`FLP_CFG_RST);
    end else begin
      pready_o <= setup & ~pready_o;
      if (setup) begin
        cand_q    <= cand;
        pslverr_o <= 1'b0;
        case (paddr_i)
          `FLP_OFF_CFG:  prdata_o <= {24'h0, cfg};
          `FLP_OFF_STAT: prdata_o <= {30'h0, status};
          `FLP_OFF_MASK: prdata_o <= {30'h0, mask};
          `FLP_OFF_CTRL: prdata_o <= {31'h0, loaded};
          default: begin
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // load once after reset, then only checked moves; writes before the load are refused
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg    <= flp_cfg_t'(`FLP_CFG_RST);
      loaded <= 1'b0;
    end else if (!loaded) begin
      if (nv_load_i) begin
        cfg    <= flp_cfg_t'(nv_byte_i);
        loaded <= 1'b1;
      end
    end else if (wr_cfg && move_ok) begin
      cfg <= cand_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `FLP_MASK_RST;
    end else if (access && pwrite_i && paddr_i == `FLP_OFF_MASK) begin
      mask <= pwdata_i[`FLP_NUM_EV-1:0];
    end
  end

  // events: violation from the command controller, refused config write
  always_comb begin
    ev = '0;
    ev[`FLP_EV_VIOL] = cmd_i.valid
                       && (((cmd_i.kind == FLP_CMD_PROG || cmd_i.kind == FLP_CMD_ERASE)
                            && is_protected(cfg, cmd_i.addr))
                           || (cmd_i.kind == FLP_CMD_MASS && any_prot));
    ev[`FLP_EV_REFUSE] = wr_cfg & ~(loaded & move_ok);
    clr = '0;
    if (access && pwrite_i && paddr_i == `FLP_OFF_STAT) begin
      clr = pwdata_i[`FLP_NUM_EV-1:0];
    end
  end

  // sticky bits; a set in the clearing cycle wins so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < `FLP_NUM_EV; gi++) begin : g_stat
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          status[gi] <= 1'b0;
        end else begin
          status[gi] <= ev[gi] | (status[gi] & ~clr[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  assign protect_violation_flag_o = status[`FLP_EV_VIOL];

  // must be combinational: the controller decides in the cycle it presents the address
  assign addr_protected_o = is_protected(cfg, cmd_i.addr);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_setup;
    psel_i && !penable_i && pwrite_i && paddr_i == `FLP_OFF_CFG;
  endsequence

  sequence s_cfg_access;
    psel_i && penable_i && pready_o;
  endsequence

  a_bus_ready: assert property (setup |=> pready_o)
    else $error("no ready one cycle after setup");

  a_refused_write: assert property (
    s_cfg_setup ##1 (s_cfg_access and (loaded && !move_ok)) |=> $stable(cfg_bits))
    else $error("refused write changed the register");

  a_accepted_write: assert property (
    s_cfg_setup ##1 (s_cfg_access and (loaded && move_ok)) |=> cfg_bits == $past(cand_q))
    else $error("allowed write not taken");

  a_read_current: assert property (
    psel_i && !penable_i && !pwrite_i && paddr_i == `FLP_OFF_CFG
    |=> prdata_o == {24'h0, $past(cfg_bits)})
    else $error("read value differs from register");

  a_pol_no_set: assert property ($past(loaded) |-> !$rose(c_pol))
    else $error("polarity bit was set again");

  a_hsize_frozen: assert property (
    $past(loaded) && !$past(c_hoff) |-> $stable(cfg.high_window_size))
    else $error("high size changed while window on");

  a_lsize_frozen: assert property (
    $past(loaded) && !$past(c_loff) |-> $stable(cfg.low_window_size))
    else $error("low size changed while window on");

  a_no_prot: assert property (c_pol && c_hoff && c_loff |-> !addr_protected_o)
    else $error("protected with no window");

  a_full_prot: assert property (!c_pol && c_hoff && c_loff |-> addr_protected_o)
    else $error("full array not protected");

  a_hi_window: assert property (
    c_pol && !c_hoff && c_loff && cfg.high_window_size == 2'h0
    |-> addr_protected_o == (cmd_i.addr >= 16'hf800))
    else $error("high window edge wrong");

  a_lo_window: assert property (
    c_pol && c_hoff && !c_loff && cfg.low_window_size == 2'h3
    |-> addr_protected_o == (cmd_i.addr >= 16'h4000 && cmd_i.addr <= 16'h5fff))
    else $error("low window edge wrong");

  a_viol_flag: assert property (
    cmd_i.valid && cmd_i.kind == FLP_CMD_PROG && addr_protected_o
    |=> protect_violation_flag_o)
    else $error("violation flag not raised");

  a_nv_load: assert property (!loaded && nv_load_i |=> cfg_bits == $past(nv_byte_i))
    else $error("stored byte not loaded");

  // own copy of the move table, held against real register changes
  localparam logic [63:0] PERM_CHK = `FLP_PERM_TABLE;

  a_perm_move: assert property (
    $past(loaded) && $changed(cfg_bits)
    |-> PERM_CHK[{$past(c_pol), $past(c_hoff), $past(c_loff), c_pol, c_hoff, c_loff}])
    else $error("register moved to a scenario not allowed");

  a_early_refuse: assert property (
    s_cfg_setup ##1 (s_cfg_access and (!loaded && !nv_load_i)) |=> $stable(cfg_bits))
    else $error("write taken before the stored byte");

  a_refuse_flag: assert property (
    wr_cfg && !(loaded && move_ok) |=> status[`FLP_EV_REFUSE])
    else $error("refused write not flagged");

  a_mass_viol: assert property (
    cmd_i.valid && cmd_i.kind == FLP_CMD_MASS && !(c_pol && c_hoff && c_loff)
    |=> protect_violation_flag_o)
    else $error("mass erase under protection not flagged");

  a_mass_free: assert property (
    cmd_i.valid && cmd_i.kind == FLP_CMD_MASS && c_pol && c_hoff && c_loff
    && !protect_violation_flag_o |=> !protect_violation_flag_o)
    else $error("mass erase flagged with no protection");

  // a clear in the event cycle must not hide the event
  a_set_wins: assert property (ev[`FLP_EV_VIOL] |=> protect_violation_flag_o)
    else $error("violation lost");

  a_irq_high: assert property ((status & mask) != 2'h0 |=> irq_o)
    else $error("interrupt not raised");

  a_irq_low: assert property ((status & mask) == 2'h0 |=> !irq_o)
    else $error("interrupt without unmasked status");

  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held over two cycles");

  a_unmapped_err: assert property (
    setup && !(paddr_i inside {`FLP_OFF_CFG, `FLP_OFF_STAT, `FLP_OFF_MASK, `FLP_OFF_CTRL})
    |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped address not flagged");

  a_mapped_ok: assert property (
    setup && (paddr_i inside {`FLP_OFF_CFG, `FLP_OFF_STAT, `FLP_OFF_MASK, `FLP_OFF_CTRL})
    |=> !pslverr_o)
    else $error("error on a mapped address");

  a_open_both: assert property (
    !c_pol && !c_hoff && !c_loff
    && cfg.high_window_size == 2'h0 && cfg.low_window_size == 2'h0
    |-> addr_protected_o == !(cmd_i.addr >= 16'hf800
                              || (cmd_i.addr >= 16'h4000 && cmd_i.addr <= 16'h43ff)))
    else $error("open windows wrong");

endmodule

// ==== tb/flp_flash_ctrl_model.sv ====
// flash command controller model: stored protection byte and command stream
// assumes the bench calls its tasks right after a rising edge of clk_i
`timescale 1ns/1ns
module flp_flash_ctrl_model
  import flp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic addr_protected_i,
  output logic      nv_load_o,
  output logic [7:0] nv_byte_o,
  output flp_cmd_t  cmd_o
);
  initial begin
    nv_load_o = 1'b0;
    nv_byte_o = 8'h00;
    cmd_o = '0;
  end
  // one load per reset; spare bit left erased
  task automatic load(input logic [7:0] b);
    nv_load_o <= 1'b1;
    nv_byte_o <= b | 8'h40;
    @(posedge clk_i);
    nv_load_o <= 1'b0;
    nv_byte_o <= ~b; // released byte must not look valid
    @(posedge clk_i);
  endtask
  task automatic issue(input logic v, input flp_cmd_e k, input logic [15:0] a,
                       output logic p);
    cmd_o <= '{v, k, a};
    @(posedge clk_i);
    p = addr_protected_i;
    cmd_o <= '{1'b0, FLP_CMD_OTHER, ~a};
    @(posedge clk_i);
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the flash range protection block
// assumes flp_pkg, the defines header and the controller model are compiled
`timescale 1ns/1ns
`include "flp_defines.svh"
module testbench
  import flp_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic nv_load, prot, viol, irq, p;
  logic [7:0] paddr, nv_byte;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] hb, le;
  flp_cmd_t cmd;
  int n_fail, comparisons;

  flp_protect dut_u (.clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .nv_load_i(nv_load), .nv_byte_i(nv_byte),
    .cmd_i(cmd), .addr_protected_o(prot), .protect_violation_flag_o(viol), .irq_o(irq));
  flp_flash_ctrl_model part_u (.clk_i(clk), .addr_protected_i(prot),
    .nv_load_o(nv_load), .nv_byte_o(nv_byte), .cmd_o(cmd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, p);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, p);
    chk(q, e);
  endtask
  task automatic probe(input flp_cmd_e k, input logic [15:0] a, input logic e);
    part_u.issue(k != FLP_CMD_OTHER, k, a, p);
    chk({31'h0, p}, {31'h0, e});
  endtask
  task automatic rst_load();
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wr(`FLP_OFF_CFG, 32'hff);
    rdc(`FLP_OFF_CFG, 32'h24);
    probe(FLP_CMD_OTHER, 16'h8000, 1'b1);
    part_u.load(8'hff);
    rdc(`FLP_OFF_CFG, 32'hff);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    comparisons = 0;
    for (int k = 0; k < 4; k++) begin
      rst_load();
      wr(`FLP_OFF_CFG, 32'hc0 | (k << 3) | k);
      rdc(`FLP_OFF_CFG, 32'hc0 | (k << 3) | k);
      hb = 16'h0 - (16'h0800 << k);
      le = 16'h4000 + (16'h0400 << k) - 16'h1;
      probe(FLP_CMD_OTHER, hb, 1'b1);
      probe(FLP_CMD_OTHER, hb - 16'h1, 1'b0);
      probe(FLP_CMD_OTHER, le, 1'b1);
      probe(FLP_CMD_OTHER, le + 16'h1, 1'b0);
      probe(FLP_CMD_OTHER, 16'h3fff, 1'b0);
    end
    // sizes locked while windows enabled, so 0xc0 keeps 11/11
    wr(`FLP_OFF_CFG, 32'hc0);
    rdc(`FLP_OFF_CFG, 32'hdb);
    wr(`FLP_OFF_STAT, 32'h3);
    wr(`FLP_OFF_CFG, 32'he4);
    rdc(`FLP_OFF_CFG, 32'hdb);
    rdc(`FLP_OFF_STAT, 32'h2);
    wr(`FLP_OFF_MASK, 32'h1);
    probe(FLP_CMD_PROG, 16'hc000, 1'b1);
    @(posedge clk);
    chk({30'h0, viol, irq}, 32'h3);
    wr(`FLP_OFF_STAT, 32'h3);
    rdc(`FLP_OFF_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    probe(FLP_CMD_MASS, 16'h0000, 1'b0);
    @(posedge clk);
    chk({31'h0, viol}, 32'h1);
    wr(`FLP_OFF_CFG, 32'h64);
    rdc(`FLP_OFF_CFG, 32'h7f);
    probe(FLP_CMD_OTHER, 16'h0000, 1'b1);
    wr(`FLP_OFF_CFG, 32'he4);
    rdc(`FLP_OFF_CFG, 32'h64);
    rst_load();
    probe(FLP_CMD_MASS, 16'h0000, 1'b0);
    @(posedge clk);
    chk({31'h0, viol}, 32'h0);
    wr(`FLP_OFF_CFG, 32'h40);
    rdc(`FLP_OFF_CFG, 32'h40);
    probe(FLP_CMD_OTHER, 16'hf800, 1'b0);
    probe(FLP_CMD_OTHER, 16'hf7ff, 1'b1);
    probe(FLP_CMD_OTHER, 16'h43ff, 1'b0);
    probe(FLP_CMD_ERASE, 16'h4400, 1'b1);
    @(posedge clk);
    chk({31'h0, viol}, 32'h1);
    rst_load();
    wr(`FLP_OFF_CFG, 32'hc4);
    rdc(`FLP_OFF_CFG, 32'hc4);
    probe(FLP_CMD_OTHER, 16'hf800, 1'b1);
    probe(FLP_CMD_OTHER, 16'hf7ff, 1'b0);
    probe(FLP_CMD_OTHER, 16'h4000, 1'b0);
    rst_load();
    wr(`FLP_OFF_CFG, 32'he3);
    rdc(`FLP_OFF_CFG, 32'he3);
    probe(FLP_CMD_OTHER, 16'h5fff, 1'b1);
    probe(FLP_CMD_OTHER, 16'h6000, 1'b0);
    probe(FLP_CMD_OTHER, 16'hf800, 1'b0);
    apb(1'b0, 8'h10, 32'h0, p);
    chk({q[30:0], p}, 32'h1);
    summarize();
  end
endmodule
